/* rtl/ucal_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the calibration engine
// Assumes: Avalon-MM word addressing with 32-bit data
// Notes:   Included by its bare name
`ifndef UCAL_DEFINES_SVH
`define UCAL_DEFINES_SVH

`define UCAL_NUM_CH        8
`define UCAL_CODE_W        12
`define UCAL_ADDR_W        6
// Word index = group * 8 + channel; group in address bits 5:3
`define UCAL_GRP_CFG       3'h0
`define UCAL_GRP_INPUT     3'h1
`define UCAL_GRP_GAIN      3'h2
`define UCAL_GRP_ZERO      3'h3
`define UCAL_GRP_DATA      3'h4
`define UCAL_GRP_LATCH     3'h5
`define UCAL_CFG_IDX_CTRL  3'h0
`define UCAL_CFG_IDX_STAT  3'h1
`define UCAL_CTRL_ENA_BIT  0
`define UCAL_CTRL_LOAD_BIT 1
`define UCAL_GAIN_RST      12'h800
`define UCAL_ZERO_RST      12'h000
`define UCAL_INPUT_RST     12'h000
`define UCAL_GAIN_BIAS     13'h0800
`define UCAL_PROD_SHIFT    12
`define UCAL_CODE_MAX      15'h0FFF
`define UCAL_MUL_CYCLES    2
`define UCAL_UNMAPPED_RD   32'h00000000

`endif

/* rtl/ucal_engine.sv */
// Purpose: Eight-channel gain and zero user calibration with one shared engine
// Assumes: Avalon-MM slave, synchronous active-high reset, 40 MHz clock
// Notes:   Latch load is a control bit that copies all data registers to the latches
//
// Behaviour
// - Each of eight channels owns its own gain and zero correction code.
// - Enabled correction multiplies input by gain code and adds zero code.
// - Corrected result goes to the data register, later moved into the latch.
// - With correction on, writing input, gain or zero reruns correction for that channel.
// - Gain coefficient spans one half to one and a half.
// - Zero offset is signed, minus 2048 to plus 2047 codes.
// - One correction engine serves all eight channels.
// - Enable bit set corrects; cleared passes input straight to data register.
// - With correction off, gain or zero writes only store, no calculation.
// - With correction off, gain and zero reads return last written values.
// - Channels 0-3 form group A, channels 4-7 form group B.
// - The 12-bit latch code selects the resistor-string tap of its channel.
// - Reset: gain 2048, zero 0, input 0.
// - Gain is straight binary, zero is twos complement, whatever the data format.
// - Reads return data in the format they were written.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`include "ucal_defines.svh"

module ucal_engine (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [11:0] latch_code_o [`UCAL_NUM_CH],
	output logic      [3:0]  group_a_busy_o,
	output logic      [3:0]  group_b_busy_o
);

	// Bus decode
	wire [2:0]  bus_grp     = avs_address[5:3];
	wire [2:0]  bus_ch      = avs_address[2:0];
	wire        lane_ok     = avs_byteenable[0] && avs_byteenable[1];
	wire [11:0] wr_code     = avs_writedata[11:0];
	wire        wr_input    = avs_write && !avs_waitrequest && lane_ok && bus_grp == `UCAL_GRP_INPUT;
	wire        wr_gain     = avs_write && !avs_waitrequest && lane_ok && bus_grp == `UCAL_GRP_GAIN;
	wire        wr_zero     = avs_write && !avs_waitrequest && lane_ok && bus_grp == `UCAL_GRP_ZERO;
	wire        wr_ctrl     = avs_write && !avs_waitrequest && avs_byteenable[0]
	                          && bus_grp == `UCAL_GRP_CFG && bus_ch == `UCAL_CFG_IDX_CTRL;

	logic        ena_reg;
	logic        rd_pend_reg;
	logic [5:0]  rd_addr_reg;
	logic [7:0]  pend_reg;
	logic [7:0]  pend_next;
	logic [2:0]  cur_ch_reg;
	logic [25:0] prod_reg;
	logic [11:0] data_reg  [`UCAL_NUM_CH];
	logic [11:0] latch_reg [`UCAL_NUM_CH];
	logic [11:0] in_all    [`UCAL_NUM_CH];
	logic [11:0] gain_all  [`UCAL_NUM_CH];
	logic [11:0] zero_all  [`UCAL_NUM_CH];
	logic [11:0] in_rd;
	logic [11:0] gain_rd;
	logic [11:0] zero_rd;
	ucal_pkg::ucal_state_t state_reg;
	ucal_pkg::ucal_state_t state_next;
	ucal_pkg::ucal_store_t store;

	// One store per field; no format conversion so reads match writes
	ucal_reg_mem #(.RST_VAL(`UCAL_INPUT_RST)) u_input (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (wr_input),
		.wr_addr_i (bus_ch),
		.wr_data_i (wr_code),
		.rd_addr_i (bus_ch),
		.rd_data_o (in_rd),
		.all_data_o(in_all)
	);
	ucal_reg_mem #(.RST_VAL(`UCAL_GAIN_RST)) u_gain (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (wr_gain),
		.wr_addr_i (bus_ch),
		.wr_data_i (wr_code),
		.rd_addr_i (bus_ch),
		.rd_data_o (gain_rd),
		.all_data_o(gain_all)
	);
	ucal_reg_mem #(.RST_VAL(`UCAL_ZERO_RST)) u_zero (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (wr_zero),
		.wr_addr_i (bus_ch),
		.wr_data_i (wr_code),
		.rd_addr_i (bus_ch),
		.rd_data_o (zero_rd),
		.all_data_o(zero_all)
	);

	// Reads wait one cycle so the memory's registered output is ready
	assign avs_waitrequest = avs_read && !rd_pend_reg;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rd_pend_reg <= 1'b0;
			rd_addr_reg <= 6'h00;
		end else begin
			rd_pend_reg <= avs_read && !rd_pend_reg;
			rd_addr_reg <= avs_address;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			ena_reg <= 1'b0;
		else if (wr_ctrl)
			ena_reg <= avs_writedata[`UCAL_CTRL_ENA_BIT];
	end

	// Correction requests: a bit per channel, so repeats merge and none is lost while enable stays set
	wire ena_write  = wr_input || ((wr_gain || wr_zero) && ena_reg);
	wire [7:0] req_set = ena_reg && ena_write ? 8'h01 << bus_ch : 8'h00;
	wire start      = state_reg == ucal_pkg::UCAL_IDLE && |pend_reg;
	logic [2:0] pick_ch;

	always_comb begin
		pick_ch = 3'h0;
		for (int i = `UCAL_NUM_CH - 1; i >= 0; i--) begin
			if (pend_reg[i])
				pick_ch = 3'(i);
		end
	end

	always_comb begin
		pend_next = pend_reg;
		if (start)
			pend_next[pick_ch] = 1'b0;
		pend_next = pend_next | req_set;
		if (!ena_reg)
			pend_next = 8'h00;
	end

	// Shared engine: multiply, then add and saturate
	wire [12:0] gain_eff = {1'b0, gain_all[cur_ch_reg]} + `UCAL_GAIN_BIAS;
	wire [14:0] scaled   = {1'b0, prod_reg[25:`UCAL_PROD_SHIFT]};
	wire [14:0] zero_sx  = {{3{zero_all[cur_ch_reg][11]}}, zero_all[cur_ch_reg]};
	wire [14:0] sum      = scaled + zero_sx;
	wire [11:0] sat_code = sum[14] ? 12'h000 :
	                       (sum > `UCAL_CODE_MAX) ? 12'hFFF : sum[11:0];

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ucal_pkg::UCAL_IDLE:  if (start) state_next = ucal_pkg::UCAL_MUL;
			ucal_pkg::UCAL_MUL:   state_next = ucal_pkg::UCAL_STORE;
			ucal_pkg::UCAL_STORE: state_next = ucal_pkg::UCAL_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_reg  <= ucal_pkg::UCAL_IDLE;
			pend_reg   <= 8'h00;
			cur_ch_reg <= 3'h0;
			prod_reg   <= 26'h0000000;
		end else begin
			state_reg <= state_next;
			pend_reg  <= pend_next;
			if (start)
				cur_ch_reg <= pick_ch;
			if (state_reg == ucal_pkg::UCAL_MUL)
				prod_reg <= 26'(in_all[cur_ch_reg] * gain_eff);
		end
	end

	// Bypass write beats a result of a stale calculation on the same channel
	always_comb begin
		store = '0;
		if (!ena_reg && wr_input) begin
			store.valid = 1'b1;
			store.chan  = bus_ch;
			store.code  = wr_code;
		end else if (ena_reg && state_reg == ucal_pkg::UCAL_STORE) begin
			store.valid = 1'b1;
			store.chan  = cur_ch_reg;
			store.code  = sat_code;
		end
	end

	wire load_all = wr_ctrl && avs_writedata[`UCAL_CTRL_LOAD_BIT];

	genvar g;
	generate
		for (g = 0; g < `UCAL_NUM_CH; g++) begin : g_ch
			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					data_reg[g]  <= `UCAL_INPUT_RST;
					latch_reg[g] <= `UCAL_INPUT_RST;
				end else begin
					if (store.valid && store.chan == 3'(g))
						data_reg[g] <= store.code;
					if (load_all)
						latch_reg[g] <= data_reg[g];
				end
			end
			assign latch_code_o[g] = latch_reg[g];
		end
	endgenerate

	// Group membership shows in per-group pending status
	assign group_a_busy_o = pend_reg[3:0];
	assign group_b_busy_o = pend_reg[7:4];

	wire [2:0]  rd_grp = rd_addr_reg[5:3];
	wire [2:0]  rd_ch  = rd_addr_reg[2:0];
	wire [31:0] cfg_rd = rd_ch == `UCAL_CFG_IDX_CTRL ? {31'h0, ena_reg} :
	                     rd_ch == `UCAL_CFG_IDX_STAT ?
	                     {23'h0, state_reg != ucal_pkg::UCAL_IDLE, pend_reg} : `UCAL_UNMAPPED_RD;

	always_comb begin
		unique case (rd_grp)
			`UCAL_GRP_CFG:   avs_readdata = cfg_rd;
			`UCAL_GRP_INPUT: avs_readdata = {20'h0, in_rd};
			`UCAL_GRP_GAIN:  avs_readdata = {20'h0, gain_rd};
			`UCAL_GRP_ZERO:  avs_readdata = {20'h0, zero_rd};
			`UCAL_GRP_DATA:  avs_readdata = {20'h0, data_reg[rd_ch]};
			`UCAL_GRP_LATCH: avs_readdata = {20'h0, latch_reg[rd_ch]};
			default:         avs_readdata = `UCAL_UNMAPPED_RD;
		endcase
	end

	// Checks
	a_bypass_pass: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!ena_reg && wr_input) |=> data_reg[$past(bus_ch)] == $past(wr_code))
		else $error("bypass write did not reach data register");
	a_no_calc_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!ena_reg && (wr_gain || wr_zero)) |=> pend_reg == 8'h00)
		else $error("calculation queued while correction off");
	a_write_queues: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(ena_reg && ena_write) |=> pend_reg[$past(bus_ch)] || state_reg != ucal_pkg::UCAL_IDLE)
		else $error("enabled write did not queue correction");
	a_engine_seq: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		start |=> state_reg == ucal_pkg::UCAL_MUL ##1 state_reg == ucal_pkg::UCAL_STORE)
		else $error("engine sequence broken");
	a_store_value: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(ena_reg && state_reg == ucal_pkg::UCAL_STORE && !wr_input) |=> data_reg[$past(cur_ch_reg)] == $past(sat_code))
		else $error("corrected code not stored");
	a_pend_served: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(ena_reg && pend_reg != 8'h00 && state_reg == ucal_pkg::UCAL_IDLE) |=> state_reg == ucal_pkg::UCAL_MUL || !ena_reg)
		else $error("pending request not started");
	a_sat_range: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(sum[14]) |-> sat_code == 12'h000)
		else $error("negative result not clamped");
	a_latch_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		load_all |=> latch_reg[0] == $past(data_reg[0]) && latch_reg[7] == $past(data_reg[7]))
		else $error("latch load failed");
	a_read_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(avs_read && avs_waitrequest) |=> !avs_waitrequest)
		else $error("read held off more than one cycle");

	c_bypass: cover property (@(posedge ref_clk_i) disable iff (rst_i) !ena_reg && wr_input);
	c_calc:   cover property (@(posedge ref_clk_i) disable iff (rst_i) ena_reg && state_reg == ucal_pkg::UCAL_STORE);
	c_queue:  cover property (@(posedge ref_clk_i) disable iff (rst_i) $countones(pend_reg) > 1);
	c_load:   cover property (@(posedge ref_clk_i) disable iff (rst_i) load_all);

endmodule

/* rtl/ucal_pkg.sv */
// Purpose: Types shared by the calibration engine files
// Assumes: Constants come from ucal_defines.svh
// Notes:   Nothing here is imported; use ucal_pkg::name
package ucal_pkg;

	typedef enum logic [1:0] {
		UCAL_IDLE,
		UCAL_MUL,
		UCAL_STORE
	} ucal_state_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  chan;
		logic [11:0] code;
	} ucal_store_t;

endpackage

/* rtl/ucal_reg_mem.sv */
// Purpose: Eight-entry, 12-bit register store with registered read port
// Assumes: One synchronous write port and one synchronous read port, plus an unregistered output of every entry
// Notes:   Reset loads every entry with RST_VAL
`include "ucal_defines.svh"

module ucal_reg_mem #(
	parameter logic [11:0] RST_VAL = 12'h000
) (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        wr_en_i,
	input  wire logic [2:0]  wr_addr_i,
	input  wire logic [11:0] wr_data_i,
	input  wire logic [2:0]  rd_addr_i,
	output logic      [11:0] rd_data_o,
	output logic      [11:0] all_data_o [`UCAL_NUM_CH]
);

	logic [11:0] mem_reg [`UCAL_NUM_CH];

	genvar g;
	generate
		for (g = 0; g < `UCAL_NUM_CH; g++) begin : g_ent
			always_ff @(posedge ref_clk_i) begin
				if (rst_i)
					mem_reg[g] <= RST_VAL;
				else if (wr_en_i && wr_addr_i == 3'(g))
					mem_reg[g] <= wr_data_i;
			end
			assign all_data_o[g] = mem_reg[g];
		end
	endgenerate

	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			rd_data_o <= RST_VAL;
		else
			rd_data_o <= mem_reg[rd_addr_i];
	end

endmodule

/* testbench/testbench.sv */
// Purpose: Self-checking bench of the calibration engine
// Assumes: ucal_host_model carries every register access
// Notes:   Shadows of input, gain and zero give the expected codes
`include "ucal_defines.svh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        go = 1'b0;
	logic        wr_r = 1'b0;
	logic        en = 1'b0;
	logic        done, awr, ard, wq;
	logic [5:0]  addr = 6'h00;
	logic [5:0]  aa;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] s = 32'h4437B119;
	logic [31:0] rdat, q, awd, ard_d;
	logic [3:0]  abe, ga, gb;
	logic [11:0] latch [8];
	logic [11:0] im [8], gm [8], zm [8], dm [8];
	int          error_cnt = 0;
	int          tests_run = 0;

	always #12.5 clk = ~clk;

	ucal_host_model u_ucal_host_model (.ref_clk_i(clk), .go_i(go), .wr_i(wr_r), .addr_i(addr), .data_i(wdat),
		.avs_waitrequest(wq), .avs_readdata(ard_d), .avs_address(aa), .avs_read(ard), .avs_write(awr),
		.avs_writedata(awd), .avs_byteenable(abe), .rd_o(rdat), .done_o(done));
	ucal_engine u_ucal_engine (.ref_clk_i(clk), .rst_i(rst), .avs_address(aa), .avs_read(ard), .avs_write(awr),
		.avs_writedata(awd), .avs_byteenable(abe), .avs_readdata(ard_d), .avs_waitrequest(wq),
		.latch_code_o(latch), .group_a_busy_o(ga), .group_b_busy_o(gb));

	function automatic logic [31:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	// Clamps rather than wraps, so a large zero offset cannot fold the code round
	function automatic logic [11:0] corr(input logic [11:0] x, input logic [11:0] g, input logic [11:0] z);
		int v;
		v = (int'(x) * (int'(g) + 2048)) / 4096 + int'($signed(z));
		return (v < 0) ? 12'h000 : (v > 4095) ? 12'hFFF : v[11:0];
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		go <= 1'b1;
		wr_r <= w;
		addr <= ad;
		wdat <= d;
		do begin
			@(posedge clk);
			go <= 1'b0;
			#1;
			n++;
		end while (done !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
		end
		q = rdat;
	endtask

	task automatic put(input logic [2:0] g, input logic [2:0] c, input logic [11:0] v);
		bus(1'b1, {g, c}, {20'h00000, v});
		if (g == 3'h1) im[c] = v;
		if (g == 3'h2) gm[c] = v;
		if (g == 3'h3) zm[c] = v;
		if (en) dm[c] = corr(im[c], gm[c], zm[c]);
		else if (g == 3'h1) dm[c] = v;
	endtask

	task automatic drain();
		repeat (40) begin
			bus(1'b0, 6'h01, 32'h00000000);
			if (q[8:0] === 9'h000) break;
		end
		chk(q, 32'h00000000);
	endtask

	task automatic check_all();
		logic [11:0] e;
		for (int c = 0; c < 8; c++) begin
			for (int g = 1; g < 5; g++) begin
				e = (g == 1) ? im[c] : (g == 2) ? gm[c] : (g == 3) ? zm[c] : dm[c];
				bus(1'b0, {g[2:0], c[2:0]}, 32'h00000000);
				chk(q, {20'h00000, e});
			end
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		error_cnt++;
		wrap_up();
	end

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int c = 0; c < 8; c++) begin
			im[c] = `UCAL_INPUT_RST;
			gm[c] = `UCAL_GAIN_RST;
			zm[c] = `UCAL_ZERO_RST;
			dm[c] = 12'h000;
		end
		check_all();
		repeat (12) put(3'(1 + rnd() % 3), 3'(rnd() % 8), 12'(rnd()));
		check_all();
		bus(1'b1, 6'h00, 32'h00000001);
		en = 1'b1;
		put(3'h2, 3'h6, 12'h800);
		// The request shows in the busy flags for one cycle only, before the engine takes it
		chk({24'h000000, gb, ga}, 32'h00000040);
		drain();
		// Gain and offset at both ends of their spans
		put(3'h2, 3'h0, 12'h000);
		put(3'h1, 3'h0, 12'hFFF);
		put(3'h2, 3'h1, 12'hFFF);
		put(3'h1, 3'h1, 12'hFFF);
		put(3'h3, 3'h2, 12'h800);
		put(3'h1, 3'h2, 12'h010);
		put(3'h3, 3'h3, 12'h7FF);
		put(3'h1, 3'h3, 12'h900);
		repeat (30) put(3'(1 + rnd() % 3), 3'(rnd() % 8), 12'(rnd()));
		drain();
		check_all();
		bus(1'b1, 6'h22, 32'h00000123);
		bus(1'b0, 6'h30, 32'h00000000);
		chk(q, `UCAL_UNMAPPED_RD);
		bus(1'b1, 6'h00, 32'h00000003);
		@(posedge clk);
		#1;
		for (int c = 0; c < 8; c++) begin
			chk({20'h00000, latch[c]}, {20'h00000, dm[c]});
			bus(1'b0, {3'h5, c[2:0]}, 32'h00000000);
			chk(q, {20'h00000, dm[c]});
		end
		check_all();
		wrap_up();
	end
endmodule

/* testbench/ucal_host_model.sv */
// Purpose: Host side of the register port, one Avalon-MM transfer per go pulse
// Assumes: go_i comes high for one edge while no transfer is open
// Notes:   A released address and data bus shows the inverse of its last value
module ucal_host_model (
	input  wire logic        ref_clk_i,
	input  wire logic        go_i,
	input  wire logic        wr_i,
	input  wire logic [5:0]  addr_i,
	input  wire logic [31:0] data_i,
	input  wire logic        avs_waitrequest,
	input  wire logic [31:0] avs_readdata,
	output logic      [5:0]  avs_address = 6'h00,
	output logic             avs_read = 1'b0,
	output logic             avs_write = 1'b0,
	output logic      [31:0] avs_writedata = 32'h00000000,
	output logic      [3:0]  avs_byteenable = 4'hF,
	output logic      [31:0] rd_o = 32'h00000000,
	output logic             done_o = 1'b0
);
	timeunit 1ns;
	timeprecision 100ps;
	wire logic open_w = avs_read | avs_write;

	always_ff @(posedge ref_clk_i) begin
		done_o <= 1'b0;
		if (open_w && !avs_waitrequest) begin
			rd_o <= avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			avs_address <= ~avs_address;
			avs_writedata <= ~avs_writedata;
			done_o <= 1'b1;
		end else if (go_i && !open_w) begin
			avs_address <= addr_i;
			avs_writedata <= data_i;
			avs_read <= !wr_i;
			avs_write <= wr_i;
		end
	end
endmodule
